// *** pkg/scdp_pkg.sv ***
// Purpose: Shared constants for the serial configuration and data port
// Assumes: Both ends run on core_clk at 40 MHz; link clock made by the master end
// Notes:   Header byte is rw, burst, six-bit address, top bit first
package scdp_pkg;
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned ADDR_W         = 6;
  localparam int unsigned BYTE_W         = 8;
  localparam int unsigned BIT_RW         = 7;
  localparam int unsigned BIT_BURST      = 6;
  localparam int unsigned ST_RDY_BIT     = 7;
  localparam int unsigned ST_STATE_LSB   = 4;
  localparam int unsigned ST_FREE_W      = 4;
  localparam logic [5:0]  STAT_LO        = 6'h30;
  localparam logic [5:0]  STAT_HI        = 6'h3d;
  localparam logic [5:0]  FIFO_ADDR      = 6'h3f;
  localparam int unsigned NUM_REGS       = 47;
  localparam logic [7:0]  REG_DEFAULT    = 8'h00;
  localparam int unsigned WAKE_US        = 150;
  localparam int unsigned WAKE_CYC       = (WAKE_US * (CLK_HZ / 1_000_000));
  localparam int unsigned GAP_NS         = 100;
  localparam int unsigned GAP_CYC        = (GAP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SCLK_DIV       = 4;
  localparam int unsigned READY_CYC      = 4;
endpackage : scdp_pkg

// *** pkg/scdp_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Four serial wires between the master and the device
interface scdp_if;
  logic sclk;
  logic chip_select_low;
  logic si;
  logic so;
  logic so_oe;
  modport dev (input sclk, input chip_select_low, input si, output so, output so_oe);
  modport mst (output sclk, output chip_select_low, output si, input so, input so_oe);
endinterface : scdp_if
`default_nettype wire

// *** src/scdp_device.sv ***
// Purpose: Device end of the serial port, registers and transmit buffer front end
// Assumes: Link pins are asynchronous to core_clk and pass two flops
// Notes:   Buffer writes leave through a two-entry skid buffer
`timescale 1ns/1ps
`default_nettype none
module scdp_device
  import scdp_pkg::*;
#(
  parameter int unsigned WAKE_CYCLES = WAKE_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  scdp_if.dev             link,
  input  wire logic       sleeping,
  input  wire logic       oscillator_off_state,
  input  wire logic [2:0] main_state,
  input  wire logic [3:0] free_bytes,
  output logic            strobe_valid,
  output logic [5:0]      strobe_addr,
  input  wire logic [7:0] stat_data,
  output logic [5:0]      stat_addr,
  output logic            fifo_valid,
  output logic [7:0]      fifo_data,
  input  wire logic       fifo_ready,
  output logic [7:0]      cfg_data_out,
  input  wire logic [5:0] cfg_addr
);
  logic [2:0] sclk_sync_reg, cs_sync_reg, si_sync_reg;
  logic       sclk_d_reg;
  logic [14:0] wake_cnt_reg;
  logic        ready_reg;
  logic [7:0]  shin_reg, shout_reg;
  logic [2:0]  bitcnt_reg;
  logic        hdr_done_reg, rw_reg, burst_reg;
  logic [5:0]  addr_reg;
  logic [7:0]  regs_reg [NUM_REGS];
  logic [1:0]  sk_cnt_reg;
  logic [7:0]  sk_d0_reg, sk_d1_reg;
  logic        cs_act, rise, fall, wr_byte, byte_done;
  logic [7:0]  byte_in, status_byte, rd_byte;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_sync_reg <= 3'h0;
      cs_sync_reg   <= 3'h7;
      si_sync_reg   <= 3'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], link.sclk};
      cs_sync_reg   <= {cs_sync_reg[1:0], link.chip_select_low};
      si_sync_reg   <= {si_sync_reg[1:0], link.si};
    end
  end
  assign cs_act = !cs_sync_reg[1];
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) sclk_d_reg <= 1'b0;
    else          sclk_d_reg <= sclk_sync_reg[1];
  end
  assign rise = cs_act && sclk_sync_reg[1] && !sclk_d_reg;
  assign fall = cs_act && !sclk_sync_reg[1] && sclk_d_reg;

  // Wake-up delay models oscillator start when select arrives in sleep or with the oscillator off
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_cnt_reg <= 15'h0;
      ready_reg    <= 1'b0;
    end else if (!cs_act) begin
      wake_cnt_reg <= 15'h0;
      ready_reg    <= 1'b0;
    end else if (!(sleeping || oscillator_off_state)) begin
      ready_reg    <= 1'b1;
    end else if (wake_cnt_reg >= WAKE_CYCLES[14:0]) begin
      ready_reg    <= 1'b1;
    end else begin
      wake_cnt_reg <= wake_cnt_reg + 15'h1;
    end
  end

  assign status_byte = {!ready_reg, main_state, free_bytes};
  assign byte_in     = {shin_reg[6:0], si_sync_reg[1]};
  assign byte_done   = rise && (bitcnt_reg == 3'h7);
  assign stat_addr   = addr_reg;
  always_comb begin
    rd_byte = REG_DEFAULT;
    if (addr_reg >= STAT_LO && addr_reg <= STAT_HI) rd_byte = stat_data;
    else if (addr_reg < ADDR_W'(NUM_REGS))          rd_byte = regs_reg[addr_reg];
  end
  assign wr_byte = byte_done && hdr_done_reg && !rw_reg;

  // Shift engine; select release drops any partial byte
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      shin_reg     <= 8'h0;
      shout_reg    <= 8'h0;
      bitcnt_reg   <= 3'h0;
      hdr_done_reg <= 1'b0;
      rw_reg       <= 1'b0;
      burst_reg    <= 1'b0;
      addr_reg     <= 6'h0;
    end else if (!cs_act) begin
      bitcnt_reg   <= 3'h0;
      hdr_done_reg <= 1'b0;
      shout_reg    <= status_byte;
    end else begin
      if (rise) begin
        shin_reg   <= byte_in;
        bitcnt_reg <= bitcnt_reg + 3'h1;
      end
      if (byte_done && !hdr_done_reg) begin
        rw_reg    <= byte_in[BIT_RW];
        burst_reg <= byte_in[BIT_BURST];
        addr_reg  <= byte_in[ADDR_W-1:0];
        hdr_done_reg <= !(byte_in[ADDR_W-1:0] >= STAT_LO && byte_in[ADDR_W-1:0] <= STAT_HI
                          && !byte_in[BIT_BURST]);
      end else if (byte_done) begin
        if (burst_reg && addr_reg != FIFO_ADDR) addr_reg <= addr_reg + 6'h1;
        else if (!burst_reg) hdr_done_reg <= 1'b0;
      end
      if (fall && bitcnt_reg == 3'h0)
        shout_reg <= (hdr_done_reg && rw_reg) ? rd_byte : status_byte;
      else if (fall)
        shout_reg <= {shout_reg[6:0], 1'b0};
      else if (bitcnt_reg == 3'h0 && !hdr_done_reg)
        shout_reg <= status_byte;
    end
  end

  // Strobe pulse when a non-burst header lands in the strobe range
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      strobe_valid <= 1'b0;
      strobe_addr  <= 6'h0;
    end else begin
      strobe_valid <= byte_done && !hdr_done_reg && !byte_in[BIT_BURST]
                      && byte_in[ADDR_W-1:0] >= STAT_LO && byte_in[ADDR_W-1:0] <= STAT_HI;
      if (byte_done && !hdr_done_reg) strobe_addr <= byte_in[ADDR_W-1:0];
    end
  end

  // Configuration registers; reset loads defaults
  for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) regs_reg[g] <= REG_DEFAULT;
      else if (wr_byte && addr_reg == ADDR_W'(g)) regs_reg[g] <= byte_in;
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) cfg_data_out <= REG_DEFAULT;
    else          cfg_data_out <= (cfg_addr < ADDR_W'(NUM_REGS)) ? regs_reg[cfg_addr] : 8'h00;
  end

  // Two-entry buffer; a full buffer drops further link bytes since SPI cannot stall
  logic push, pop;
  assign push = wr_byte && addr_reg == FIFO_ADDR && sk_cnt_reg != 2'h2;
  assign pop  = fifo_valid && fifo_ready;
  assign fifo_valid = sk_cnt_reg != 2'h0;
  assign fifo_data  = sk_d0_reg;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sk_cnt_reg <= 2'h0;
      sk_d0_reg  <= 8'h0;
      sk_d1_reg  <= 8'h0;
    end else begin
      if (pop) sk_d0_reg <= sk_d1_reg;
      if (push) begin
        if (sk_cnt_reg == 2'h0 || (sk_cnt_reg == 2'h1 && pop)) sk_d0_reg <= byte_in;
        else sk_d1_reg <= byte_in;
      end
      sk_cnt_reg <= sk_cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  assign link.so    = shout_reg[BYTE_W-1];
  assign link.so_oe = cs_act;
endmodule : scdp_device
`default_nettype wire

// *** src/scdp_master.sv ***
// Purpose: Master end; runs one header plus data bytes per request
// Assumes: Device output reaches this end asynchronously
// Notes:   Two-entry buffer holds returned bytes until the user takes them; bytes returned while it is full are dropped
`timescale 1ns/1ps
`default_nettype none
module scdp_master
  import scdp_pkg::*;
#(
  parameter int unsigned WAKE_CYCLES = WAKE_CYC,
  parameter int unsigned DIV         = SCLK_DIV
) (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  scdp_if.mst             link,
  input  wire logic       req_valid,
  output logic            req_ready,
  input  wire logic       req_rw,
  input  wire logic       req_burst,
  input  wire logic [5:0] req_addr,
  input  wire logic [3:0] req_len,
  input  wire logic       wdata_valid,
  output logic            wdata_ready,
  input  wire logic [7:0] wdata,
  output logic            rdata_valid,
  output logic [7:0]      rdata,
  input  wire logic       rdata_ready,
  input  wire logic       wait_ready
);
  typedef enum logic [2:0] {IDLE, WAITRDY, SHIFT, GAP, DONE} scdp_mst_e;
  scdp_mst_e   st_reg;
  logic [1:0]  so_sync_reg;
  logic [15:0] cnt_reg;
  logic [3:0]  left_reg;
  logic [2:0]  bit_reg;
  logic        phase_reg, sclk_reg, cs_reg, rw_reg;
  logic [7:0]  sh_reg, rx_reg;
  logic [1:0]  rb_cnt_reg;
  logic [7:0]  rb0_reg, rb1_reg;
  logic        tick, push, pop;
  logic [7:0]  rx_byte;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) so_sync_reg <= 2'h3;
    else          so_sync_reg <= {so_sync_reg[0], link.so_oe ? link.so : 1'b1};
  end
  assign tick      = (cnt_reg == 16'(DIV - 1));
  assign req_ready = (st_reg == IDLE);
  assign wdata_ready = (st_reg == GAP) && !rw_reg && tick && left_reg != 4'h0;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= IDLE;
      cnt_reg <= 16'h0;
      left_reg <= 4'h0;
      bit_reg <= 3'h0;
      phase_reg <= 1'b0;
      sclk_reg <= 1'b0;
      cs_reg <= 1'b1;
      rw_reg <= 1'b0;
      sh_reg <= 8'h0;
      rx_reg <= 8'h0;
    end else begin
      cnt_reg <= tick ? 16'h0 : cnt_reg + 16'h1;
      case (st_reg)
        IDLE: if (req_valid) begin
          cs_reg   <= 1'b0;
          rw_reg   <= req_rw;
          left_reg <= req_len;
          sh_reg   <= {req_rw, req_burst, req_addr};
          cnt_reg  <= 16'h0;
          st_reg   <= WAITRDY;
        end
        WAITRDY: begin
          if ((wait_ready && !so_sync_reg[1]) ||
              (!wait_ready && cnt_reg == 16'(WAKE_CYCLES - 1))) begin
            st_reg <= SHIFT;
            cnt_reg <= 16'h0;
            bit_reg <= 3'h0;
            phase_reg <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg + 16'h1;
          end
        end
        SHIFT: if (tick) begin
          phase_reg <= !phase_reg;
          sclk_reg  <= !phase_reg;
          // Sample just before the fall; the returned bit lags by the far synchroniser
          if (phase_reg) begin
            rx_reg  <= rx_byte;
            sh_reg  <= {sh_reg[6:0], 1'b0};
            bit_reg <= bit_reg + 3'h1;
            if (bit_reg == 3'h7) st_reg <= GAP;
          end
        end
        GAP: if (tick) begin
          if (left_reg == 4'h0) st_reg <= DONE;
          else if (rw_reg || wdata_valid) begin
            sh_reg   <= rw_reg ? 8'h00 : wdata;
            left_reg <= left_reg - 4'h1;
            st_reg   <= SHIFT;
          end
        end
        DONE: if (tick) begin
          cs_reg <= 1'b1;
          st_reg <= IDLE;
        end
        default: st_reg <= IDLE;
      endcase
    end
  end
  assign push = (st_reg == SHIFT) && tick && phase_reg && bit_reg == 3'h7 && rb_cnt_reg != 2'h2;
  assign rx_byte = {rx_reg[6:0], so_sync_reg[1]};
  assign pop  = rdata_valid && rdata_ready;
  assign rdata_valid = rb_cnt_reg != 2'h0;
  assign rdata = rb0_reg;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rb_cnt_reg <= 2'h0;
      rb0_reg <= 8'h0;
      rb1_reg <= 8'h0;
    end else begin
      if (pop) rb0_reg <= rb1_reg;
      if (push) begin
        if (rb_cnt_reg == 2'h0 || (rb_cnt_reg == 2'h1 && pop)) rb0_reg <= rx_byte;
        else rb1_reg <= rx_byte;
      end
      rb_cnt_reg <= rb_cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
  assign link.sclk            = sclk_reg;
  assign link.chip_select_low = cs_reg;
  assign link.si              = sh_reg[BYTE_W-1];
endmodule : scdp_master
`default_nettype wire

// *** testbench/scdp_monitor.sv ***
// Purpose: Wire-level checks on the serial link between the two ends
// Assumes: Link signals are sampled on core_clk; master divider DIV is 4
// Notes:   Reset input is the master-side reset so aborts disable checks
`timescale 1ns/1ps
`default_nettype none
module scdp_monitor (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic chip_select_low,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe
);
  logic       sclk_d_reg;
  logic       rdy_seen_reg;
  logic [7:0] rise_cnt_reg;
  wire logic  sclk_rise = sclk && !sclk_d_reg;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) sclk_d_reg <= 1'b0;
    else sclk_d_reg <= sclk;
  end

  // Ready latch clears with select so each frame must see it again
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) rdy_seen_reg <= 1'b0;
    else if (chip_select_low) rdy_seen_reg <= 1'b0;
    else if (so_oe && !so) rdy_seen_reg <= 1'b1;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) rise_cnt_reg <= 8'h00;
    else if (chip_select_low) rise_cnt_reg <= 8'h00;
    else if (sclk_rise) rise_cnt_reg <= rise_cnt_reg + 8'h01;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_clk_high;
    sclk [*4] ##1 !sclk;
  endsequence
  sequence s_last_bit;
    sclk_rise && rise_cnt_reg[2:0] == 3'h7;
  endsequence

  property p_oe_on;      $fell(chip_select_low) |-> ##[1:4] so_oe; endproperty
  property p_oe_off;     $rose(chip_select_low) |-> ##[1:4] !so_oe; endproperty
  property p_ready_first; sclk_rise |-> rdy_seen_reg; endproperty
  property p_status_top; (sclk_rise && rise_cnt_reg == 8'h00) |-> !so; endproperty
  property p_clk_in_frame; sclk |-> !chip_select_low; endproperty
  property p_si_stable;  $rose(sclk) |-> $stable(si); endproperty
  property p_clk_high;   $rose(sclk) |-> s_clk_high; endproperty
  property p_byte_gap;   s_last_bit |-> ##1 (!sclk_rise) [*8]; endproperty

  a_oe_on: assert property (p_oe_on) else $error("output not enabled after select");
  a_oe_off: assert property (p_oe_off) else $error("output kept after select");
  a_ready_first: assert property (p_ready_first) else $error("clock before ready");
  a_status_top: assert property (p_status_top) else $error("ready bit not low");
  a_clk_in_frame: assert property (p_clk_in_frame) else $error("clock outside frame");
  a_si_stable: assert property (p_si_stable) else $error("input moved at rise");
  a_clk_high: assert property (p_clk_high) else $error("clock high time wrong");
  a_byte_gap: assert property (p_byte_gap) else $error("no gap between bytes");
endmodule : scdp_monitor
`default_nettype wire

// *** testbench/serial_config_data_port_test.sv ***
// Purpose: Drives both ends joined by the link and checks bytes and registers
// Assumes: Wake-up shortened to 20 cycles; status inputs held at fixed values
// Notes:   Abort is made by resetting the master alone in mid-byte
`timescale 1ns/1ps
`default_nettype none
module serial_config_data_port_test;
  import scdp_pkg::*;
  localparam int unsigned WK = 20;
  localparam logic [2:0] MS = 3'h2;
  localparam logic [3:0] FB = 4'h9;
  localparam logic [7:0] ST = {1'b0, MS, FB};
  logic core_clk = 1'b0, reset_n = 1'b0, abort_n = 1'b1;
  logic sleeping, oscillator_off_state, fifo_ready, req_valid, req_rw, req_burst;
  logic wdata_valid = 1'b0, rdata_ready, wait_ready;
  logic strobe_valid, fifo_valid, req_ready, wdata_ready, rdata_valid;
  logic [2:0] main_state;
  logic [3:0] free_bytes, req_len;
  logic [5:0] strobe_addr, stat_addr, cfg_addr, req_addr;
  logic [7:0] stat_data, fifo_data, cfg_data_out, wdata = 8'h00, rdata;
  logic [7:0] wq[$], rq[$], fq[$], sq[$];
  int mismatches = 0, comparisons = 0;
  wire logic m_rst_n = reset_n & abort_n;

  scdp_if scdp_if_i ();
  scdp_device #(.WAKE_CYCLES(WK)) scdp_device_i (.core_clk(core_clk), .reset_n(reset_n),
    .link(scdp_if_i), .sleeping(sleeping), .oscillator_off_state(oscillator_off_state),
    .main_state(main_state), .free_bytes(free_bytes), .strobe_valid(strobe_valid),
    .strobe_addr(strobe_addr), .stat_data(stat_data), .stat_addr(stat_addr),
    .fifo_valid(fifo_valid), .fifo_data(fifo_data), .fifo_ready(fifo_ready),
    .cfg_data_out(cfg_data_out), .cfg_addr(cfg_addr));
  scdp_master #(.WAKE_CYCLES(WK)) scdp_master_i (.core_clk(core_clk), .reset_n(m_rst_n),
    .link(scdp_if_i), .req_valid(req_valid), .req_ready(req_ready), .req_rw(req_rw),
    .req_burst(req_burst), .req_addr(req_addr), .req_len(req_len),
    .wdata_valid(wdata_valid), .wdata_ready(wdata_ready), .wdata(wdata),
    .rdata_valid(rdata_valid), .rdata(rdata), .rdata_ready(rdata_ready),
    .wait_ready(wait_ready));
  scdp_monitor scdp_monitor_i (.core_clk(core_clk), .reset_n(m_rst_n),
    .sclk(scdp_if_i.sclk), .chip_select_low(scdp_if_i.chip_select_low),
    .si(scdp_if_i.si), .so(scdp_if_i.so), .so_oe(scdp_if_i.so_oe));

  always #12.5 core_clk = ~core_clk;

  always @(negedge core_clk) begin
    wdata_valid <= (wq.size() > 0);
    if (wq.size() > 0) wdata <= wq[0];
  end

  // Transfers are recorded after inputs settle and before the edge that takes them
  always @(negedge core_clk) begin
    #5;
    if (wdata_valid && wdata_ready) void'(wq.pop_front());
    if (rdata_valid && rdata_ready) rq.push_back(rdata);
    if (fifo_valid && fifo_ready) fq.push_back(fifo_data);
    if (strobe_valid) sq.push_back({2'b00, strobe_addr});
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Empties the queue whatever happened, so one slip does not cascade
  task automatic cmpq(inout logic [7:0] q[$], input logic [7:0] e[$]);
    chk("count", 8'(e.size()), 8'(q.size()));
    foreach (e[i]) chk("byte", e[i], q.pop_front());
    q.delete();
  endtask : cmpq

  task automatic cfg(input logic [5:0] a, input logic [7:0] e);
    @(negedge core_clk) cfg_addr = a;
    repeat (2) @(negedge core_clk);
    chk("cfg", e, cfg_data_out);
  endtask : cfg

  task automatic run(input logic rw, input logic b, input logic [5:0] a, input logic [3:0] n);
    @(negedge core_clk);
    {req_rw, req_burst, req_addr, req_len} = {rw, b, a, n};
    req_valid = 1'b1;
    while (req_ready !== 1'b1) @(negedge core_clk);
    @(negedge core_clk) req_valid = 1'b0;
    while (req_ready !== 1'b1) @(negedge core_clk);
    repeat (8) @(negedge core_clk);
  endtask : run

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    stop_test();
  end

  initial begin
    {sleeping, oscillator_off_state, req_valid, req_rw, req_burst} = 5'h00;
    {fifo_ready, rdata_ready, wait_ready} = 3'h7;
    {main_state, free_bytes, stat_data} = {MS, FB, 8'h5a};
    {cfg_addr, req_addr, req_len} = 16'h0000;
    repeat (20) @(negedge core_clk);
    reset_n = 1'b1;
    cfg(6'h05, REG_DEFAULT);
    run(1'b1, 1'b0, 6'h05, 4'h1);
    cmpq(rq, {ST, REG_DEFAULT});
    wq.push_back(8'ha5);
    run(1'b0, 1'b0, 6'h05, 4'h1);
    cmpq(rq, {ST, ST});
    cfg(6'h05, 8'ha5);
    run(1'b1, 1'b0, 6'h05, 4'h1);
    cmpq(rq, {ST, 8'ha5});
    wq = {8'h11, 8'h22, 8'h33};
    run(1'b0, 1'b1, 6'h10, 4'h3);
    cfg(6'h12, 8'h33);
    rq.delete();
    run(1'b1, 1'b1, 6'h10, 4'h3);
    cmpq(rq, {ST, 8'h11, 8'h22, 8'h33});
    run(1'b0, 1'b0, 6'h33, 4'h0);
    cmpq(sq, {8'h33});
    cmpq(rq, {ST});
    run(1'b1, 1'b1, 6'h35, 4'h1);
    cmpq(rq, {ST, 8'h5a});
    {fifo_ready, rdata_ready} = 2'b00;
    wq = {8'hc1, 8'hc2, 8'hc3};
    run(1'b0, 1'b1, FIFO_ADDR, 4'h3);
    chk("held", 8'h00, 8'(fq.size()));
    {fifo_ready, rdata_ready} = 2'b11;
    repeat (6) @(negedge core_clk);
    cmpq(fq, {8'hc1, 8'hc2});
    cmpq(rq, {ST, ST});
    {sleeping, oscillator_off_state} = 2'b11;
    run(1'b1, 1'b0, 6'h05, 4'h1);
    cmpq(rq, {ST, 8'ha5});
    {sleeping, oscillator_off_state, wait_ready} = 3'b000;
    run(1'b1, 1'b1, 6'h11, 4'h1);
    cmpq(rq, {ST, 8'h22});
    wq.push_back(8'h77);
    fork
      begin
        repeat (110) @(negedge core_clk);
        abort_n = 1'b0;
        @(negedge core_clk) abort_n = 1'b1;
      end
    join_none
    run(1'b0, 1'b0, 6'h20, 4'h1);
    wq.delete();
    cfg(6'h20, REG_DEFAULT);
    wq.push_back(8'h44);
    run(1'b0, 1'b0, 6'h20, 4'h1);
    cfg(6'h20, 8'h44);
    stop_test();
  end
endmodule : serial_config_data_port_test
`default_nettype wire
